// ==== rxb1_defines.vh ====
// register offsets, fields, reset values for the buffer 1 control block
`ifndef RXB1_DEFINES_VH
`define RXB1_DEFINES_VH
`define OFF_CTRL        8'h00
`define OFF_IRQ_STATUS  8'h04
`define OFF_IRQ_ENABLE  8'h08
`define OFF_IRQ_CLEAR   8'h0c
`define OFF_SPILL       8'h10
`define BIT_FULL        7
`define BIT_MODE_HI     6
`define BIT_MODE_LO     5
`define BIT_RTR         3
`define MODE_ALL_ERR    2'h3
`define MODE_EXT        2'h2
`define MODE_STD        2'h1
`define MODE_VALID      2'h0
`define CODE_MAX        3'h5
`define CODE_SPILL_MAX  3'h1
`define RST_CTRL        8'h00
`define IRQ_STORED      0
`define IRQ_DROPPED     1
`endif

// ==== rxb1_accept.v ====
// acceptance decision from receive mode and frame attributes
`timescale 1ns/1ps
`default_nettype none
`include "rxb1_defines.vh"
module rxb1_accept (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire [1:0] mode,
  input  wire       frame_valid,
  input  wire       frame_error,
  input  wire       frame_extended,
  output reg        accept_reg
);
  reg accept_next;
  always @* begin
    accept_next = 1'b0;
    case (mode)
      `MODE_ALL_ERR: accept_next = frame_valid;
      `MODE_EXT:     accept_next = frame_valid & ~frame_error & frame_extended;
      `MODE_STD:     accept_next = frame_valid & ~frame_error & ~frame_extended;
      `MODE_VALID:   accept_next = frame_valid & ~frame_error;
      default:       accept_next = 1'b0;
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      accept_reg <= 1'b0;
    end else begin
      accept_reg <= accept_next;
    end
  end
endmodule
`default_nettype wire

// ==== rxb1_control.v ====
// buffer 1 control and status register with ahb-lite slave
//
// Notes on behaviour
// - mode 11 accepts everything; mode 10 only valid extended frames.
// - mode 01 only valid standard frames; mode 00 every valid frame.
// - read-only remote request flag shows stored frame was remote; writes ignored.
// - three-bit filter hit code names admitting filter; 110, 111 never produced.
// - codes 000 and 001 only when buffer 0 spill enable set.
//
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rxb1_defines.vh"
module rxb1_control (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        frame_valid,
  input  wire        frame_error,
  input  wire        frame_extended,
  input  wire        frame_remote,
  input  wire [2:0]  frame_filter,
  output reg         irq,
  output reg         spill_enable
);
  reg        full_reg;
  reg [1:0]  mode_reg;
  reg        rtr_reg;
  reg [2:0]  hit_reg;
  reg [1:0]  irq_status_reg;
  reg [1:0]  irq_enable_reg;
  reg        wr_pend_reg;
  reg [7:0]  wr_addr_reg;
  reg        rtr_hold_reg;
  reg [2:0]  filt_hold_reg;
  wire       accept;
  wire       code_ok;
  wire       store;
  wire       drop;
  wire       clr_full;
  wire [1:0] irq_clr;
  wire       rd_req;
  reg [31:0] rd_next;

  // accept decision is registered, so frame details are held one cycle too
  rxb1_accept u_accept (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .mode           (mode_reg),
    .frame_valid    (frame_valid),
    .frame_error    (frame_error),
    .frame_extended (frame_extended),
    .accept_reg     (accept)
  );

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rtr_hold_reg  <= 1'b0;
      filt_hold_reg <= 3'h0;
    end else begin
      rtr_hold_reg  <= frame_remote;
      filt_hold_reg <= frame_filter;
    end
  end

  assign code_ok = (filt_hold_reg <= `CODE_MAX) &&
                   ((filt_hold_reg > `CODE_SPILL_MAX) || spill_enable);
  // full buffer is not overwritten; the frame sets the dropped status bit
  assign store    = accept & code_ok & ~full_reg;
  assign drop     = accept & code_ok & full_reg;
  assign clr_full = wr_pend_reg && (wr_addr_reg == `OFF_CTRL) && !hwdata[`BIT_FULL];
  assign irq_clr  = (wr_pend_reg && (wr_addr_reg == `OFF_IRQ_CLEAR)) ? hwdata[1:0] : 2'h0;
  assign rd_req   = hsel && hready && htrans[1] && !hwrite;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_reg       <= 1'b0;
      mode_reg       <= 2'h0;
      rtr_reg        <= 1'b0;
      hit_reg        <= 3'h0;
      spill_enable   <= 1'b0;
      irq_status_reg <= 2'h0;
      irq_enable_reg <= 2'h0;
      irq            <= 1'b0;
    end else begin
      // store sets full, wins over clear
      if (store) begin
        full_reg <= 1'b1;
      end else if (clr_full) begin
        full_reg <= 1'b0;
      end
      if (store) begin
        rtr_reg <= rtr_hold_reg;
        hit_reg <= filt_hold_reg;
      end
      if (wr_pend_reg && wr_addr_reg == `OFF_CTRL) begin
        mode_reg <= hwdata[`BIT_MODE_HI:`BIT_MODE_LO];
      end
      if (wr_pend_reg && wr_addr_reg == `OFF_SPILL) begin
        spill_enable <= hwdata[0];
      end
      if (wr_pend_reg && wr_addr_reg == `OFF_IRQ_ENABLE) begin
        irq_enable_reg <= hwdata[1:0];
      end
      // set wins over clear
      irq_status_reg <= (irq_status_reg & ~irq_clr) | {drop, store};
      irq <= |(((irq_status_reg & ~irq_clr) | {drop, store}) & irq_enable_reg);
    end
  end

  always @* begin
    rd_next = 32'h0000_0000;
    case (haddr[7:0])
      `OFF_CTRL:       rd_next = {24'h0, full_reg, mode_reg, 1'b0, rtr_reg, hit_reg};
      `OFF_IRQ_STATUS: rd_next = {30'h0, irq_status_reg};
      `OFF_IRQ_ENABLE: rd_next = {30'h0, irq_enable_reg};
      `OFF_SPILL:      rd_next = {31'h0, spill_enable};
      default:         rd_next = 32'h0000_0000;
    endcase
  end

  // zero wait states; unmapped reads give zero, writes ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        wr_pend_reg <= hsel && htrans[1] && hwrite;
        wr_addr_reg <= haddr[7:0];
      end
      if (rd_req) begin
        hrdata <= rd_next;
      end
    end
  end
endmodule
`default_nettype wire

// ==== can_src.sv ====
// frame source model
`timescale 1ns/1ps
`default_nettype none
module can_src (
  input  wire logic       hclk,
  input  wire logic       send,
  input  wire logic [6:0] attrs,
  output var logic        frame_valid = 1'b0,
  output var logic [6:0]  frame_bits = 7'h00
);
  always @(posedge hclk) begin
    frame_valid <= send;
    frame_bits <= send ? attrs : ~frame_bits;
  end
endmodule
`default_nettype wire

// ==== rxb1_sva.sv ====
// bus assertions for buffer 1
`timescale 1ns/1ps
`default_nettype none
module rxb1_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        spill_enable
);
  wire rd = htrans[1] && !hwrite;
  wire sw = htrans[1] && hwrite && haddr[7:0] == 8'h10;
  wire c0 = rd && haddr[7:0] == 8'h00;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  no_wait_a: assert property (hreadyout) else $error("wait");
  hit_code_a: assert property (c0 |=> hrdata[2:1] != 2'h3) else $error("hit");
  bit4_zero_a: assert property (c0 |=> hrdata[31:8] == 0 && !hrdata[4])
    else $error("bit4");
  hole_zero_a: assert property (rd && haddr[7:0] == 8'h14 |=> hrdata == 0)
    else $error("hole");
  data_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("hold");
  spill_set_a: assert property (sw |-> ##2 spill_enable == $past(hwdata[0]))
    else $error("set");
  spill_keep_a: assert property ($changed(spill_enable) |-> $past(sw, 2))
    else $error("keep");
  cover property (c0 ##1 rd);
  cover property ($rose(spill_enable));
  cover property (sw ##2 !spill_enable);
endmodule
bind rxb1_control rxb1_sva u_sva (.hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata,
  .hrdata, .hreadyout, .spill_enable);
`default_nettype wire

// ==== rxb1_control_tb.sv ====
// random frame bench for buffer 1
`timescale 1ns/1ps
`default_nettype none
module rxb1_control_tb;
  logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, send = 1'b0, a;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, ex;
  logic [6:0]  attrs = 7'h00, v, fb;
  wire         hreadyout, frame_valid, irq, spill_enable;
  wire  [31:0] hrdata;
  int          err_count = 0, total_checks = 0, cyc = 0;
  rxb1_control u_dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .frame_valid, .irq,
    .spill_enable, .frame_error(fb[6]), .frame_extended(fb[5]), .frame_remote(fb[3]),
    .frame_filter(fb[2:0]));
  can_src u_src (.hclk, .send, .attrs, .frame_valid, .frame_bits(fb));
  initial forever #2.5 hclk = ~hclk;
  always @(posedge hclk) if (++cyc == 9000) begin
    err_count++;
    finish_test;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic frame(input logic [6:0] f);
    send <= 1'b1;
    attrs <= f;
    @(posedge hclk);
    send <= 1'b0;
    repeat (5) @(posedge hclk);
  endtask
  function automatic logic acc(input logic [6:0] f, input logic [1:0] m, input logic s);
    return (m == 2'h3 || !f[6] && (m == 2'h0 || m == {f[5], !f[5]}))
      && f[2:0] < 3'h6 && (f[2:1] != 2'h0 || s);
  endfunction
  initial begin
    r = $urandom(32'hbd44d304);
    ex = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(8'h14, 1'b0, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 65; i++) begin
      bus(8'h00, 1'b0, 32'h0);
      chk(r, ex);
      chk(irq, 1'b0);
      v = {i[3:2], 1'b0, 4'($urandom)};
      a = acc(v, i[1:0], i[4]);
      bus(8'h10, 1'b1, 32'(i[4]));
      bus(8'h08, 1'b1, 32'(i[5]));
      // bit 7 low clears full; ones hit read-only bits
      bus(8'h00, 1'b1, {25'h0, i[1:0], 5'h1f});
      ex = {24'h0, a, i[1:0], 1'b0, a ? v[3:0] : ex[3:0]};
      frame(v);
      chk(irq, a & i[5]);
      if (a) frame(~v);
      bus(8'h04, 1'b0, 32'h0);
      chk(r[0], a);
      bus(8'h0c, 1'b1, 32'h3);
    end
    finish_test;
  end
endmodule
`default_nettype wire
